/* File: pkg/nim_dec_if.sv */
/*
  Carrier between the control module and the acceptance decoder.
  Assumes both ends sit in the same core clock domain.
*/
`timescale 1ns/1ps
interface nim_dec_if;
  import nim_pkg::*;
  nim_status_t st;
  logic [NIM_NIRQ-1:0] ien;
  logic [NIM_NIRQ-1:0] irq;
  logic ext_valid;
  logic [NIM_LVL_W-1:0] ext_level;
  logic [NIM_SET_W-1:0] ext_rrs;
  logic ext_nmi;
  logic take_nmi;
  logic take_ext;
  logic take_int;

  modport ctl (output st, ien, irq, ext_valid, ext_level, ext_rrs, ext_nmi,
    input take_nmi, take_ext, take_int);
  modport dec (input st, ien, irq, ext_valid, ext_level, ext_rrs, ext_nmi,
    output take_nmi, take_ext, take_int);
endinterface

/* File: pkg/nim_pkg.sv */
/*
  Constants and types shared by the interrupt acceptance block.
  Assumes one core clock, a synchronous active-low reset and a
  register bus of 32-bit aligned words.
*/
// What this block does
// - Enable low: every maskable request, internal or external, is ignored.
// - Enable high: maskable requests pass the configured controller's mask.
// - External maskable request taken only when its level exceeds threshold.
// - Threshold 0 opens external maskable levels 1 to 63; 63 shuts them all.
// - Each of 32 internal lines has one enable bit; 1 enables, 0 disables.
// - Preemption off: no maskable request for the running shadow set taken.
// - Preemption on: same-set request taken when its level is higher.
// - Taking a maskable or nonmaskable interrupt clears the global enable.
// - Nonmaskable preempts maskable handling and is never preempted by another nonmaskable.
// - External maskable take during nonmaskable handling leaves nonmaskable mode.
// - Nonmaskable take in the normal set overwrites the saved status.
// - Nonmaskable take in a shadow set leaves the saved status untouched.
// - Noninterrupt exceptions run in the normal register set.
// - Return reloads status from saved status in set 0, else shadow copy.
// - Return may clear nonmaskable mode but never sets it.
package nim_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int NIM_LVL_W = 6;
  localparam int NIM_SET_W = 2;
  localparam int NIM_NSETS = 4;
  localparam int NIM_NIRQ = 32;
  localparam int NIM_ADDR_W = 8;
  localparam int NIM_STAT_W = 13;

  // ---------------------------------------------------------------
  // Status word, low bit first: enable, threshold, preempt,
  // external mode, nonmaskable mode, in-handler, current set
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NIM_SET_W-1:0] current_set_index;
    logic in_handler;
    logic nmi_mode;
    logic ext_mode;
    logic same_set_preempt_enable;
    logic [NIM_LVL_W-1:0] level_threshold;
    logic maskable_int_global_enable;
  } nim_status_t;

  localparam int NIM_GIE_BIT = 0;
  localparam int NIM_THR_LSB = 1;
  localparam int NIM_PRE_BIT = 7;
  localparam int NIM_EXT_BIT = 8;
  localparam int NIM_NMI_BIT = 9;
  localparam int NIM_IH_BIT = 10;
  localparam int NIM_SET_LSB = 11;

  // ---------------------------------------------------------------
  // Levels, reset values, register offsets, responses
  // ---------------------------------------------------------------
  localparam logic [NIM_LVL_W-1:0] NIM_LVL_OPEN = 6'h00;
  localparam logic [NIM_LVL_W-1:0] NIM_LVL_SHUT = 6'h3f;
  localparam logic [NIM_STAT_W-1:0] NIM_STATUS_RST = 13'h0000;
  localparam logic [31:0] NIM_LINE_EN_RST = 32'h0000_0000;
  localparam logic [NIM_ADDR_W-1:0] NIM_OFS_STATUS = 8'h00;
  localparam logic [NIM_ADDR_W-1:0] NIM_OFS_LINE_EN = 8'h04;
  localparam logic [NIM_ADDR_W-1:0] NIM_OFS_PENDING = 8'h08;
  localparam logic [NIM_ADDR_W-1:0] NIM_OFS_ESTATUS = 8'h0c;
  localparam logic [NIM_ADDR_W-1:0] NIM_OFS_SSTATUS = 8'h10;
  localparam logic [1:0] NIM_RESP_OKAY = 2'h0;
  localparam logic [1:0] NIM_RESP_SLVERR = 2'h2;

endpackage

/* File: tb/nim_far_model.sv */
/*
  Far-side model: internal request lines and an external vectored
  controller. Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module nim_far_model
(
  input wire logic aclk,
  input wire logic int_take,
  output logic [nim_pkg::NIM_NIRQ-1:0] irq,
  output logic ext_valid,
  output logic [nim_pkg::NIM_LVL_W-1:0] ext_level,
  output logic [nim_pkg::NIM_SET_W-1:0] ext_rrs,
  output logic ext_nmi
);
  import nim_pkg::*;
  // Idle lines at time zero
  initial
  begin
    irq = '0;
    ext_valid = 1'b0;
    ext_level = 6'h00;
    ext_rrs = 2'h0;
    ext_nmi = 1'b0;
  end
  // Level on the request lines
  task automatic set_irq(input logic [NIM_NIRQ-1:0] v);
    @(posedge aclk);
    irq <= v;
  endtask
  // One request, held until the core takes it
  task automatic put(input logic [NIM_LVL_W-1:0] l,
    input logic [NIM_SET_W-1:0] s, input logic n);
    @(posedge aclk);
    ext_valid <= 1'b1;
    ext_level <= l;
    ext_rrs <= s;
    ext_nmi <= n;
  endtask
  // Withdraw a request that was refused
  task automatic drop;
    @(posedge aclk);
    ext_valid <= 1'b0;
    ext_level <= ~ext_level;
  endtask
  // Released request shows inverted stale fields
  always @(posedge aclk)
  begin
    if (ext_valid && int_take)
    begin
      ext_valid <= 1'b0;
      ext_level <= ~ext_level;
      ext_rrs <= ~ext_rrs;
      ext_nmi <= ~ext_nmi;
    end
  end
endmodule

/* File: tb/nim_top_bench.sv */
/*
  Self-checking bench for the interrupt acceptance block.
  Assumes the far-side model drives request lines and controller.
*/
`timescale 1ns/1ps
module nim_top_bench;
  import nim_pkg::*;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic aclk, aresetn, awv, awy, wv, wy, bv, by, arv, ary, rv, ry;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, irq, takes, nmis;
  logic [3:0] ws;
  logic [1:0] br, rr, rrs, hs;
  logic [5:0] lvl;
  logic ev, xn, exc, eret, tk, tkn, nm;
  int failures, total_checks;
  nim_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
    .s_axi_awready(awy), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(by), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(ary), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(ry), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .irq(irq), .ext_valid(ev), .ext_level(lvl),
    .ext_rrs(rrs), .ext_nmi(xn), .exc_req(exc), .eret_req(eret),
    .int_take(tk), .int_take_nmi(tkn), .handler_set(hs), .nmi_mode(nm));
  nim_far_model i_far (.aclk(aclk), .int_take(tk), .irq(irq),
    .ext_valid(ev), .ext_level(lvl), .ext_rrs(rrs), .ext_nmi(xn));
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Count taken interrupts
  always @(posedge aclk)
  begin
    if (tk === 1'b1)
      takes <= takes + 1;
    if (tkn === 1'b1)
      nmis <= nmis + 1;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    ws <= 4'hf;
    by <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (pa && awy === 1'b1)
      begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wy === 1'b1)
      begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    while (pa || pw || bv !== 1'b1);
    r = br;
    by <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic pa;
    pa = 1'b1;
    @(posedge aclk);
    arv <= 1'b1;
    ara <= a;
    ry <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (pa && ary === 1'b1)
      begin
        pa = 1'b0;
        arv <= 1'b0;
      end
    end
    while (pa || rv !== 1'b1);
    d = rd;
    r = rr;
    ry <= 1'b0;
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bus_wr(a, d, r);
    chk("bresp", r, NIM_RESP_OKAY);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    bus_rd(a, d, r);
    chk(nm, d & m, e);
    chk("rresp", r, NIM_RESP_OKAY);
  endtask
  // Status word: enable, threshold, preempt, external mode
  function automatic logic [31:0] st(input logic e, input logic [5:0] l,
    input logic p, input logic x);
    return {23'h00_0000, x, p, l, e};
  endfunction
  task automatic pulse(input logic ret);
    @(posedge aclk);
    if (ret)
      eret <= 1'b1;
    else
      exc <= 1'b1;
    @(posedge aclk);
    exc <= 1'b0;
    eret <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic wst(input logic [31:0] v);
    wrc(NIM_OFS_STATUS, v);
    repeat (4) @(posedge aclk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] ofs [4] = '{8'h00, 8'h04, 8'h0c, 8'h10};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++)
      rdc("reset value", ofs[i], 32'hffff_ffff, 32'h0000_0000);
    wrc(NIM_OFS_LINE_EN, 32'ha5a5_0f0f);
    rdc("mask", NIM_OFS_LINE_EN, 32'hffff_ffff, 32'ha5a5_0f0f);
    wrc(NIM_OFS_PENDING, 32'hffff_ffff);
    rdc("pend wr", NIM_OFS_LINE_EN, 32'hffff_ffff, 32'ha5a5_0f0f);
    bus_wr(8'h20, 32'hffff_ffff, r);
    chk("unmapped bresp", r, NIM_RESP_SLVERR);
    bus_rd(8'h20, d, r);
    chk("unmapped rresp", r, NIM_RESP_SLVERR);
    chk("unmapped rdata", d, 32'h0000_0000);
  endtask
  task automatic t_int;
    logic [31:0] t0;
    t0 = takes;
    wrc(NIM_OFS_LINE_EN, 32'h0000_0008);
    i_far.set_irq(32'h0000_0020);
    wst(st(1'b1, 6'h00, 1'b0, 1'b0));
    chk("masked line", takes, t0);
    wst(st(1'b0, 6'h00, 1'b0, 1'b0));
    i_far.set_irq(32'h0000_0028);
    repeat (4) @(posedge aclk);
    chk("enable off", takes, t0);
    rdc("pending", NIM_OFS_PENDING, 32'hffff_ffff, 32'h0000_0008);
    wst(st(1'b1, 6'h00, 1'b0, 1'b0));
    chk("internal take", takes, t0 + 1);
    rdc("enable cleared", NIM_OFS_STATUS, 32'h0000_0001, 0);
    i_far.set_irq(32'h0000_0000);
  endtask
  task automatic t_lvl;
    logic [5:0] thr [4] = '{6'h05, 6'h04, NIM_LVL_OPEN, NIM_LVL_SHUT};
    logic [5:0] req [4] = '{6'h05, 6'h05, 6'h01, 6'h3f};
    logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] t0;
    for (int i = 0; i < 4; i++)
    begin
      t0 = takes;
      wst(st(1'b0, thr[i], 1'b0, 1'b1));
      i_far.put(req[i], 2'h0, 1'b0);
      wst(st(1'b1, thr[i], 1'b0, 1'b1));
      chk("level take", takes, t0 + ex[i]);
      if (ex[i])
        rdc("level", NIM_OFS_STATUS, 32'h0000_007e, {req[i], 1'b0});
      else
        i_far.drop();
    end
  endtask
  // Set 1 holds levels 2 and 5, set 3 level 4, set 2 the first nmi, set 0 the later two
  task automatic t_sets;
    logic [31:0] t0;
    t0 = takes;
    wst(st(1'b0, 6'h00, 1'b0, 1'b1));
    i_far.put(6'h02, 2'h1, 1'b0);
    wst(st(1'b1, 6'h00, 1'b0, 1'b1));
    chk("set entry", hs, 2'h1);
    i_far.put(6'h05, 2'h1, 1'b0);
    wst(st(1'b1, 6'h02, 1'b0, 1'b1));
    chk("same set held", takes, t0 + 1);
    wst(st(1'b1, 6'h02, 1'b1, 1'b1));
    chk("same set taken", takes, t0 + 2);
    rdc("shadow", NIM_OFS_SSTATUS, 32'hffff_ffff, 32'h0000_0d85);
    pulse(1'b1);
    rdc("eret shadow", NIM_OFS_STATUS, 32'hffff_ffff, 32'h0000_0d85);
    pulse(1'b0);
    chk("exception set", hs, 2'h0);
    pulse(1'b1);
    chk("eret saved", hs, 2'h1);
  endtask
  task automatic t_nmi;
    logic [31:0] t0;
    t0 = nmis;
    pulse(1'b0);
    // Handler keeps its own saved status marker
    wrc(NIM_OFS_ESTATUS, 32'h0000_0123);
    wst(st(1'b1, 6'h00, 1'b0, 1'b1));
    i_far.put(6'h03, 2'h2, 1'b1);
    repeat (4) @(posedge aclk);
    chk("nmi taken", nmis, t0 + 1);
    chk("nmi mode", nm, 1'b1);
    rdc("nmi clears enable", NIM_OFS_STATUS, 32'h0000_0001, 0);
    rdc("saved kept", NIM_OFS_ESTATUS, 32'hffff_ffff, 32'h0000_0123);
    i_far.put(6'h03, 2'h0, 1'b1);
    repeat (4) @(posedge aclk);
    chk("nmi not preempted", nmis, t0 + 1);
    i_far.drop();
    i_far.put(6'h04, 2'h3, 1'b0);
    wst(st(1'b1, 6'h03, 1'b0, 1'b1));
    chk("nmi left", nm, 1'b0);
    pulse(1'b1);
    chk("eret no nmi", nm, 1'b0);
    chk("eret set", hs, 2'h2);
    i_far.put(6'h06, 2'h0, 1'b1);
    repeat (4) @(posedge aclk);
    chk("nmi again", nm, 1'b1);
    rdc("saved lost", NIM_OFS_ESTATUS, 32'hffff_ffff, 32'h0000_1507);
  endtask
  // ---------------------------------------------------------------
  // Run
  // ---------------------------------------------------------------
  initial
  begin
    aresetn = 1'b0;
    {awv, wv, by, arv, ry, exc, eret} = 7'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0000_0000;
    ws = 4'h0;
    takes = 32'h0000_0000;
    nmis = 32'h0000_0000;
    failures = 0;
    total_checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_int;
    t_lvl;
    t_sets;
    t_nmi;
    close_out;
  end
  // Cut a hang short
  initial
  begin
    #100_000;
    failures++;
    close_out;
  end
endmodule

/* File: verilog/nim_accept.sv */
/*
  Acceptance decoder: decides in the current cycle whether a pending
  request is taken. Purely combinational.
  Assumes the status and mask come from registers of the control side.
*/
`timescale 1ns/1ps
module nim_accept
(
  nim_dec_if.dec d
);
  import nim_pkg::*;

  logic same_set_block;
  logic ext_req;

  // Running shadow set blocks its own requests unless preemption on
  assign same_set_block = (d.st.current_set_index != '0) &&
    (d.ext_rrs == d.st.current_set_index) &&
    !d.st.same_set_preempt_enable;
  assign ext_req = d.st.ext_mode && d.ext_valid;

  // Nonmaskable: never while a nonmaskable handler runs
  assign d.take_nmi = ext_req && d.ext_nmi && !d.st.nmi_mode;

  // External maskable: enable, strict level compare, set rule
  assign d.take_ext = ext_req && !d.ext_nmi &&
    d.st.maskable_int_global_enable &&
    (d.ext_level > d.st.level_threshold) &&
    !same_set_block;

  // Internal: enable and at least one enabled line
  assign d.take_int = !d.st.ext_mode &&
    d.st.maskable_int_global_enable &&
    (|(d.irq & d.ien));

endmodule

/* File: verilog/nim_top.sv */
/*
  Interrupt acceptance, masking and nesting control with an AXI4-Lite
  register slave. Assumes the core pulses exc_req and eret_req for one
  cycle and never both in the same cycle.
*/
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module nim_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [nim_pkg::NIM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [nim_pkg::NIM_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [nim_pkg::NIM_NIRQ-1:0] irq,
  input wire logic ext_valid,
  input wire logic [nim_pkg::NIM_LVL_W-1:0] ext_level,
  input wire logic [nim_pkg::NIM_SET_W-1:0] ext_rrs,
  input wire logic ext_nmi,
  input wire logic exc_req,
  input wire logic eret_req,
  output logic int_take,
  output logic int_take_nmi,
  output logic [nim_pkg::NIM_SET_W-1:0] handler_set,
  output logic nmi_mode
);
  import nim_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    nim_status_t st;
    nim_status_t est;
    nim_status_t [NIM_NSETS-1:0] sst;
    logic [NIM_NIRQ-1:0] ien;
    logic aw_have;
    logic [NIM_ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic take;
    logic take_nmi;
  } nim_state_t;

  nim_state_t s_r;
  nim_state_t s_nxt;
  nim_status_t restored;
  logic take_any;
  logic wr_go;

  nim_dec_if dif ();

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] nim_merge(input logic [31:0] old_w,
    input logic [31:0] new_w, input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return res;
  endfunction

  // Status word widened to a bus word
  function automatic logic [31:0] nim_word(input nim_status_t st);
    return {{(32-NIM_STAT_W){1'b0}}, st};
  endfunction

  // ---------------------------------------------------------------
  // Decoder hookup
  // ---------------------------------------------------------------
  assign dif.st = s_r.st;
  assign dif.ien = s_r.ien;
  assign dif.irq = irq;
  assign dif.ext_valid = ext_valid;
  assign dif.ext_level = ext_level;
  assign dif.ext_rrs = ext_rrs;
  assign dif.ext_nmi = ext_nmi;

  nim_accept u_accept
  (
    .d(dif.dec)
  );

  assign take_any = dif.take_nmi || dif.take_ext || dif.take_int;
  assign wr_go = s_r.aw_have && s_r.w_have && !s_r.bvalid;
  // Saved copy picked by the running set
  assign restored = (s_r.st.current_set_index == '0) ? s_r.est :
    s_r.sst[s_r.st.current_set_index];

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_have && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign int_take = s_r.take;
  assign int_take_nmi = s_r.take_nmi;
  assign handler_set = s_r.st.current_set_index;
  assign nmi_mode = s_r.st.nmi_mode;

  // ---------------------------------------------------------------
  // Next state: bus slave, then core events (hardware wins)
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [31:0] tmp;
    tmp = '0;
    s_nxt = s_r;
    s_nxt.take = 1'b0;
    s_nxt.take_nmi = 1'b0;
    // Write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    // Register write once both halves are held
    if (wr_go)
    begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = NIM_RESP_OKAY;
      unique case (s_r.awaddr)
        NIM_OFS_STATUS:
        begin
          tmp = nim_merge(nim_word(s_r.st), s_r.wdata, s_r.wstrb);
          s_nxt.st.maskable_int_global_enable = tmp[NIM_GIE_BIT];
          s_nxt.st.level_threshold = tmp[NIM_THR_LSB +: NIM_LVL_W];
          s_nxt.st.same_set_preempt_enable = tmp[NIM_PRE_BIT];
          s_nxt.st.ext_mode = tmp[NIM_EXT_BIT];
        end
        NIM_OFS_LINE_EN:
          s_nxt.ien = nim_merge(s_r.ien, s_r.wdata, s_r.wstrb);
        NIM_OFS_ESTATUS:
        begin
          tmp = nim_merge(nim_word(s_r.est), s_r.wdata, s_r.wstrb);
          s_nxt.est = tmp[NIM_STAT_W-1:0];
        end
        NIM_OFS_PENDING:
          s_nxt.bresp = NIM_RESP_OKAY;
        default:
          s_nxt.bresp = NIM_RESP_SLVERR;
      endcase
    end
    // Read channel, answered one cycle after the address
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = NIM_RESP_OKAY;
      unique case (s_axi_araddr)
        NIM_OFS_STATUS: s_nxt.rdata = nim_word(s_r.st);
        NIM_OFS_LINE_EN: s_nxt.rdata = s_r.ien;
        NIM_OFS_PENDING: s_nxt.rdata = irq & s_r.ien;
        NIM_OFS_ESTATUS: s_nxt.rdata = nim_word(s_r.est);
        NIM_OFS_SSTATUS:
          s_nxt.rdata = nim_word(s_r.sst[s_r.st.current_set_index]);
        default:
        begin
          s_nxt.rdata = '0;
          s_nxt.rresp = NIM_RESP_SLVERR;
        end
      endcase
    end
    // Core events: interrupt take, exception, return
    if (take_any)
    begin
      s_nxt.take = 1'b1;
      s_nxt.st.maskable_int_global_enable = 1'b0;
      if (dif.take_int)
        s_nxt.est = s_r.st;
      else
      begin
        s_nxt.take_nmi = dif.take_nmi;
        s_nxt.st.nmi_mode = dif.take_nmi;
        s_nxt.st.in_handler = 1'b1;
        s_nxt.st.level_threshold = ext_level;
        s_nxt.st.same_set_preempt_enable = 1'b0;
        s_nxt.st.current_set_index = ext_rrs;
        if (ext_rrs == '0)
          s_nxt.est = s_r.st;
        else
          s_nxt.sst[ext_rrs] = s_r.st;
      end
    end
    else if (exc_req)
    begin
      s_nxt.est = s_r.st;
      s_nxt.st.maskable_int_global_enable = 1'b0;
      s_nxt.st.current_set_index = '0;
    end
    else if (eret_req)
    begin
      s_nxt.st = restored;
      s_nxt.st.ext_mode = s_r.st.ext_mode;
      s_nxt.st.nmi_mode = s_r.st.nmi_mode && restored.nmi_mode;
    end
  end

  // Register the whole state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
      s_r.st <= NIM_STATUS_RST;
      s_r.est <= NIM_STATUS_RST;
      s_r.ien <= NIM_LINE_EN_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_enable_ignore: assert property (
    !s_r.st.maskable_int_global_enable |-> !dif.take_ext && !dif.take_int)
    else $error("maskable take with enable low");
  chk_int_pending: assert property (
    s_r.st.maskable_int_global_enable && !s_r.st.ext_mode &&
    (|(irq & s_r.ien)) |=> int_take && !int_take_nmi)
    else $error("enabled internal line not taken");
  chk_level_gate: assert property (
    dif.take_ext |-> ext_level > s_r.st.level_threshold)
    else $error("external take at or below threshold");
  chk_level_shut: assert property (
    s_r.st.level_threshold == NIM_LVL_SHUT |-> !dif.take_ext)
    else $error("external take with all levels shut");
  chk_level_open: assert property (
    s_r.st.ext_mode && s_r.st.maskable_int_global_enable && ext_valid &&
    !ext_nmi && s_r.st.level_threshold == NIM_LVL_OPEN && ext_level != '0 &&
    (ext_rrs != s_r.st.current_set_index ||
    s_r.st.same_set_preempt_enable) |=> int_take && !int_take_nmi)
    else $error("open threshold request not taken");
  chk_line_mask: assert property (
    dif.take_int |-> |(irq & s_r.ien))
    else $error("internal take from disabled line");
  chk_same_set: assert property (
    !s_r.st.same_set_preempt_enable && s_r.st.current_set_index != '0 &&
    ext_rrs == s_r.st.current_set_index |-> !dif.take_ext)
    else $error("same set taken with preemption off");
  chk_take_disable: assert property (
    take_any |=> int_take && !s_r.st.maskable_int_global_enable)
    else $error("enable not cleared after take");
  chk_nmi_hold: assert property (
    s_r.st.nmi_mode |-> !dif.take_nmi)
    else $error("nonmaskable handler preempted");
  chk_nmi_entry: assert property (
    s_r.st.ext_mode && ext_valid && ext_nmi && !s_r.st.nmi_mode
    |=> int_take_nmi && nmi_mode && handler_set == $past(ext_rrs))
    else $error("nonmaskable request not taken");
  chk_nmi_exit: assert property (
    s_r.st.nmi_mode && dif.take_ext |=> !nmi_mode)
    else $error("nonmaskable mode kept after maskable take");
  chk_nmi_est: assert property (
    dif.take_nmi |=> (($past(ext_rrs) == '0) ? s_r.est == $past(s_r.st)
    : $stable(s_r.est)))
    else $error("saved status wrong after nonmaskable take");
  chk_exc_set: assert property (
    exc_req && !take_any |=> handler_set == '0 && s_r.est == $past(s_r.st))
    else $error("exception not in normal set");
  chk_eret_src: assert property (
    eret_req && !take_any && !exc_req |=> s_r.st.level_threshold ==
    $past(restored.level_threshold))
    else $error("return restored wrong copy");
  chk_eret_nmi: assert property (
    eret_req && !take_any && !exc_req && !s_r.st.nmi_mode |=> !nmi_mode)
    else $error("return entered nonmaskable mode");

  cov_int_take: cover property (dif.take_int ##1 int_take);
  cov_nmi_nest: cover property (s_r.st.in_handler && dif.take_nmi);
  cov_nmi_exit: cover property (s_r.st.nmi_mode && dif.take_ext);
  cov_eret_shadow: cover property (eret_req && handler_set != '0);

endmodule
